/* rtl/ssl_pkg.sv */
// package: constants and carriers for the synthesiser serial load block
package ssl_pkg;

  // ****************************************************************
  // register map (byte addresses on the apb bus)
  // ****************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CLEAR = 8'h04;
  localparam logic [7:0] REG_IRQ_EN = 8'h08;
  localparam logic [7:0] REG_FREQ_A = 8'h0c;
  localparam logic [7:0] REG_FREQ_B = 8'h10;
  localparam logic [7:0] REG_REF = 8'h14;
  localparam logic [7:0] REG_SWALLOW = 8'h18;
  localparam logic [7:0] REG_LIVE = 8'h1c;

  // ****************************************************************
  // serial word layout
  // ****************************************************************
  localparam int SHIFT_W = 24;
  localparam int FREQ_W = 22;
  localparam int REF_W = 16;
  localparam int SWALLOW_W = 4;
  localparam int DIV_W = 13;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] LEN_FREQ = 5'h18; // 24 bits
  localparam logic [CNT_W-1:0] LEN_REF = 5'h12; // 18 bits
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
  localparam int DEST_LSB = 0; // last two bits shifted in
  localparam int PAYLOAD_LSB = 2;
  // reference word fields
  localparam int REF_DIV_LSB = 0;
  localparam int REF_CTRL_A_BIT = 13;
  localparam int REF_CTRL_B_BIT = 14;
  localparam int REF_PRESCALE_BIT = 15;

  // ****************************************************************
  // interrupt events
  // ****************************************************************
  localparam int EV_W = 6;
  localparam int EV_LOAD_A = 0;
  localparam int EV_LOAD_B = 1;
  localparam int EV_LOAD_SW = 2;
  localparam int EV_LOAD_REF = 3;
  localparam int EV_LEN_ERR = 4;
  localparam int EV_LOCK_CHG = 5;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    SSL_DEST_A = 2'b00,
    SSL_DEST_SW = 2'b01,
    SSL_DEST_B = 2'b10,
    SSL_DEST_REF = 2'b11
  } ssl_dest_e;

  // pins arriving from outside the clock domain
  typedef struct packed {
    logic ser_data;
    logic ser_clk;
    logic ser_en;
    logic freq_word_select;
    logic pump2_in_window;
    logic power_down;
  } ssl_pins_s;

  localparam int PINS_W = 6;

  // phase detector enable outputs
  typedef struct packed {
    logic monitor_on;
    logic pump1_on;
    logic pump2_on;
  } ssl_pump_s;

endpackage : ssl_pkg

/* rtl/ssl_sync3.sv */
// module: three flip-flop synchroniser with agreement filter per bit
`timescale 1ns/100ps
module ssl_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // asynchronous inputs
  input wire logic [W-1:0] din,
  // filtered levels and one-cycle edge pulses
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // ****************************************************************
  // per bit: stage 1 feeds only stage 2; level moves when 2 and 3 agree
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      wire agree = (s2_reg == s3_reg);
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (agree)
            lvl_reg <= s3_reg;
        end
      end
      assign level[i] = lvl_reg;
      assign rise[i] = agree & s3_reg & ~lvl_reg;
      assign fall[i] = agree & ~s3_reg & lvl_reg;
    end
  endgenerate

endmodule : ssl_sync3

/* rtl/ssl_irq.sv */
// module: sticky event status, write-one-to-clear, enable and interrupt
`timescale 1ns/100ps
module ssl_irq #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // events from the block
  input wire logic [W-1:0] event_in,
  // software access
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [W-1:0] wdata,
  // state
  output logic [W-1:0] status,
  output logic [W-1:0] enable,
  output logic irq
);

  logic [W-1:0] en_reg;

  // ****************************************************************
  // sticky bits: a set in the clearing cycle wins
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      logic flag_reg;
      wire clr = clr_wr & wdata[i];
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
          flag_reg <= 1'b0;
        else if (event_in[i])
          flag_reg <= 1'b1;
        else if (clr)
          flag_reg <= 1'b0;
      end
      assign status[i] = flag_reg;
    end
  endgenerate

  // enable register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      en_reg <= '0;
    else if (en_wr)
      en_reg <= wdata;
  end

  assign enable = en_reg;
  assign irq = |(status & en_reg);

endmodule : ssl_irq

/* rtl/ssl_ctrl.sv */
// module: serial word loader, word buffers and pump enable logic
//
// Operation
// (R1) frequency word loads are exactly 24 serial bits in one enable frame.
// (R2) reference word loads are exactly 18 serial bits in one enable frame.
// (R3) controller sends three framed words, 66 bits, for full programming.
// (R4) with divide-by-8/9 the controller writes zero to the spare bit.
// (R5) shift register and buffers keep contents during power-down.
// (R6) new words are accepted and latched while powered down.
// (R7) control bits 00: monitors off, both charge pumps on.
// (R8) control bits a=1 b=0: monitors on, pump 1 off, pump 2 on.
// (R9) bit b=1: pump 1 gated by lock, pump 2 on; monitors off if a=0.
// (R10) control bits 11: monitors on, pump 2 on, pump 1 lock-gated.
// (R11) lock output low while pump 2 sits in its window, else high.
// (R12) lock-gated pump 1 runs while unlocked and stops at lock.
// (R13) pump-1-only loops must be programmed with pump 1 always on.
// (R14) enable fall copies shift data to buffer chosen by last two bits.
// (R15) controller shifts each word most significant bit first.
// (R16) select high drives dividers from word a, low from word b.
// (R17) data sampled on serial clock rise only while enable is high.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module ssl_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial bus and device pins
  input wire logic ser_data,
  input wire logic ser_clk,
  input wire logic ser_en,
  input wire logic freq_word_select,
  input wire logic pump2_in_window,
  input wire logic power_down,
  // divider controls
  output logic [ssl_pkg::FREQ_W-1:0] active_freq_word,
  output logic [ssl_pkg::DIV_W-1:0] ref_div_ratio,
  output logic [ssl_pkg::SWALLOW_W-1:0] swallow_count,
  output logic prescale_sel,
  // phase detector enables and lock
  output logic ref_divider_monitor,
  output logic loop_divider_monitor,
  output logic pump1_en,
  output logic pump2_en,
  output logic lock_detect_n,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  ssl_pkg::ssl_pins_s pins_raw;
  ssl_pkg::ssl_pins_s pins_lvl;
  ssl_pkg::ssl_pins_s pins_rise;
  ssl_pkg::ssl_pins_s pins_fall;

  assign pins_raw = '{ser_data: ser_data, ser_clk: ser_clk,
    ser_en: ser_en, freq_word_select: freq_word_select,
    pump2_in_window: pump2_in_window, power_down: power_down};

  ssl_sync3 #(.W(ssl_pkg::PINS_W)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(pins_raw),
    .level(pins_lvl),
    .rise(pins_rise),
    .fall(pins_fall)
  );

  // ****************************************************************
  // serial shift register and bit counter
  // ****************************************************************
  logic [ssl_pkg::SHIFT_W-1:0] shift_reg;
  logic [ssl_pkg::CNT_W-1:0] cnt_reg;

  // shift only on serial clock rise inside an enable frame
  wire shift_go = pins_rise.ser_clk & pins_lvl.ser_en; // R17
  wire frame_start = pins_rise.ser_en;
  wire frame_end = pins_fall.ser_en;
  wire cnt_sat = (cnt_reg == ssl_pkg::CNT_MAX);

  // msb arrives first, so the last two bits sit at the bottom
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      shift_reg <= '0;
    else if (shift_go)
      shift_reg <= {shift_reg[ssl_pkg::SHIFT_W-2:0], pins_lvl.ser_data}; // R17
  end

  // count bits in the frame, saturating
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cnt_reg <= '0;
    else if (frame_start)
      cnt_reg <= '0;
    else if (shift_go && !cnt_sat)
      cnt_reg <= cnt_reg + 5'h01;
  end

  // ****************************************************************
  // destination decode and length check
  // ****************************************************************
  ssl_pkg::ssl_dest_e dest;
  assign dest = ssl_pkg::ssl_dest_e'(shift_reg[ssl_pkg::DEST_LSB +: 2]);

  wire dest_sel_lo = shift_reg[ssl_pkg::DEST_LSB];
  wire dest_sel_hi = shift_reg[ssl_pkg::DEST_LSB+1];
  wire want_ref = dest_sel_hi & dest_sel_lo;
  wire len_ok = want_ref ? (cnt_reg == ssl_pkg::LEN_REF) // R2
                         : (cnt_reg == ssl_pkg::LEN_FREQ); // R1
  // loading is never gated by power-down
  wire load_ok = frame_end & len_ok; // R6
  wire load_a = load_ok & (dest == ssl_pkg::SSL_DEST_A); // R14
  wire load_b = load_ok & (dest == ssl_pkg::SSL_DEST_B); // R14
  wire load_sw = load_ok & (dest == ssl_pkg::SSL_DEST_SW); // R14
  wire load_ref = load_ok & (dest == ssl_pkg::SSL_DEST_REF); // R14
  wire len_err = frame_end & ~len_ok;

  wire [ssl_pkg::FREQ_W-1:0] freq_payload =
    shift_reg[ssl_pkg::PAYLOAD_LSB +: ssl_pkg::FREQ_W];
  wire [ssl_pkg::REF_W-1:0] ref_payload =
    shift_reg[ssl_pkg::PAYLOAD_LSB +: ssl_pkg::REF_W];
  wire [ssl_pkg::SWALLOW_W-1:0] sw_payload =
    shift_reg[ssl_pkg::PAYLOAD_LSB +: ssl_pkg::SWALLOW_W];

  // ****************************************************************
  // word buffers: reset only by sys_rst, never by power-down
  // ****************************************************************
  logic [ssl_pkg::FREQ_W-1:0] freq_word_a_reg;
  logic [ssl_pkg::FREQ_W-1:0] freq_word_b_reg;
  logic [ssl_pkg::REF_W-1:0] ref_word_reg;
  logic [ssl_pkg::SWALLOW_W-1:0] swallow_reg;

  // capture on the enable fall
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      freq_word_a_reg <= '0;
      freq_word_b_reg <= '0;
      ref_word_reg <= '0;
      swallow_reg <= '0;
    end
    else
    begin
      if (load_a)
        freq_word_a_reg <= freq_payload; // R5
      if (load_b)
        freq_word_b_reg <= freq_payload; // R5
      if (load_ref)
        ref_word_reg <= ref_payload; // R5
      if (load_sw)
        swallow_reg <= sw_payload; // R5
    end
  end

  // ****************************************************************
  // divider outputs
  // ****************************************************************
  logic [ssl_pkg::FREQ_W-1:0] active_reg;
  wire [ssl_pkg::FREQ_W-1:0] active_next =
    pins_lvl.freq_word_select ? freq_word_a_reg : freq_word_b_reg; // R16

  // select the active word each cycle
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      active_reg <= '0;
    else
      active_reg <= active_next;
  end

  assign active_freq_word = active_reg;
  assign ref_div_ratio = ref_word_reg[ssl_pkg::REF_DIV_LSB +: ssl_pkg::DIV_W];
  assign prescale_sel = ref_word_reg[ssl_pkg::REF_PRESCALE_BIT];
  assign swallow_count = swallow_reg;

  // ****************************************************************
  // lock indicator and pump enables
  // ****************************************************************
  wire locked = pins_lvl.pump2_in_window;
  wire out_ctrl_bit_a = ref_word_reg[ssl_pkg::REF_CTRL_A_BIT];
  wire out_ctrl_bit_b = ref_word_reg[ssl_pkg::REF_CTRL_B_BIT];
  logic lock_n_reg;
  ssl_pkg::ssl_pump_s pump_reg;
  ssl_pkg::ssl_pump_s pump_next;

  // b=1: pump 1 lock-gated; b=0: pump 1 on unless a forces it off
  assign pump_next.monitor_on = out_ctrl_bit_a; // R7 R8 R9 R10
  assign pump_next.pump2_on = 1'b1; // R7 R8 R9 R10
  assign pump_next.pump1_on = out_ctrl_bit_b ? ~locked // R9 R10 R12
                                             : ~out_ctrl_bit_a; // R7 R8

  // register the enables and the lock output
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pump_reg <= '0;
      lock_n_reg <= 1'b1;
    end
    else
    begin
      pump_reg <= pump_next;
      lock_n_reg <= ~locked; // R11
    end
  end

  assign ref_divider_monitor = pump_reg.monitor_on;
  assign loop_divider_monitor = pump_reg.monitor_on;
  assign pump1_en = pump_reg.pump1_on;
  assign pump2_en = pump_reg.pump2_on;
  assign lock_detect_n = lock_n_reg;

  // ****************************************************************
  // apb decode and interrupt block
  // ****************************************************************
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_status = (paddr == ssl_pkg::REG_STATUS);
  wire hit_clear = (paddr == ssl_pkg::REG_CLEAR);
  wire hit_en = (paddr == ssl_pkg::REG_IRQ_EN);
  wire hit_fa = (paddr == ssl_pkg::REG_FREQ_A);
  wire hit_fb = (paddr == ssl_pkg::REG_FREQ_B);
  wire hit_ref = (paddr == ssl_pkg::REG_REF);
  wire hit_sw = (paddr == ssl_pkg::REG_SWALLOW);
  wire hit_live = (paddr == ssl_pkg::REG_LIVE);
  wire mapped = hit_status | hit_clear | hit_en | hit_fa | hit_fb |
    hit_ref | hit_sw | hit_live;

  logic [ssl_pkg::EV_W-1:0] ev;
  logic [ssl_pkg::EV_W-1:0] irq_status;
  logic [ssl_pkg::EV_W-1:0] irq_enable;
  logic lock_prev_reg;

  // remember lock to flag its changes
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      lock_prev_reg <= 1'b0;
    else
      lock_prev_reg <= locked;
  end

  assign ev[ssl_pkg::EV_LOAD_A] = load_a;
  assign ev[ssl_pkg::EV_LOAD_B] = load_b;
  assign ev[ssl_pkg::EV_LOAD_SW] = load_sw;
  assign ev[ssl_pkg::EV_LOAD_REF] = load_ref;
  assign ev[ssl_pkg::EV_LEN_ERR] = len_err;
  assign ev[ssl_pkg::EV_LOCK_CHG] = locked ^ lock_prev_reg;

  ssl_irq #(.W(ssl_pkg::EV_W)) u_irq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .event_in(ev),
    .clr_wr(wr & hit_clear),
    .en_wr(wr & hit_en),
    .wdata(pwdata[ssl_pkg::EV_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // live state: lock, power-down, select, control bits, bit count
  wire [31:0] live_word = {22'h000000, cnt_reg, out_ctrl_bit_b,
    out_ctrl_bit_a, pins_lvl.freq_word_select, pins_lvl.power_down, locked};

  // read mux, reserved bits zero
  assign prdata =
    hit_status ? {26'h0000000, irq_status} :
    hit_en ? {26'h0000000, irq_enable} :
    hit_fa ? {10'h000, freq_word_a_reg} :
    hit_fb ? {10'h000, freq_word_b_reg} :
    hit_ref ? {16'h0000, ref_word_reg} :
    hit_sw ? {28'h0000000, swallow_reg} :
    hit_live ? live_word : 32'h00000000;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_load_a;
    load_a |=> freq_word_a_reg == $past(freq_payload);
  endproperty
  a_load_a: assert property (p_load_a) else $error("word a not loaded"); // R14

  property p_len_freq;
    frame_end && !want_ref && cnt_reg == ssl_pkg::LEN_FREQ |-> load_ok;
  endproperty
  a_len_freq: assert property (p_len_freq) else $error("24-bit load lost"); // R1

  property p_len_ref;
    frame_end && want_ref && cnt_reg == ssl_pkg::LEN_REF |=>
      ref_word_reg == $past(ref_payload);
  endproperty
  a_len_ref: assert property (p_len_ref) else $error("18-bit load lost"); // R2

  property p_hold;
    !frame_end |=> $stable(freq_word_a_reg) && $stable(ref_word_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer changed"); // R5

  property p_pd_load;
    pins_lvl.power_down && load_b |=>
      freq_word_b_reg == $past(freq_payload);
  endproperty
  a_pd_load: assert property (p_pd_load) else $error("pd load lost"); // R6

  property p_mode00;
    !out_ctrl_bit_a && !out_ctrl_bit_b ##1 $stable(ref_word_reg) |->
      pump1_en && pump2_en && !ref_divider_monitor;
  endproperty
  a_mode00: assert property (p_mode00) else $error("mode 00 wrong"); // R7

  property p_mode10;
    out_ctrl_bit_a && !out_ctrl_bit_b |=>
      !pump1_en && pump2_en && loop_divider_monitor;
  endproperty
  a_mode10: assert property (p_mode10) else $error("mode 10 wrong"); // R8

  property p_gated;
    out_ctrl_bit_b |=> pump1_en == !$past(locked) && pump2_en
      && ref_divider_monitor == $past(out_ctrl_bit_a);
  endproperty
  a_gated: assert property (p_gated) else $error("gating wrong"); // R9 R10 R12

  property p_lock;
    locked [*2] |=> !lock_detect_n;
  endproperty
  a_lock: assert property (p_lock) else $error("lock output wrong"); // R11

  property p_select;
    pins_lvl.freq_word_select |=> active_freq_word == $past(freq_word_a_reg);
  endproperty
  a_select: assert property (p_select) else $error("select wrong"); // R16

  property p_shift;
    shift_go |=> shift_reg[0] == $past(pins_lvl.ser_data);
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong"); // R17

  c_load_a: cover property (load_a);
  c_load_ref: cover property (load_ref);
  c_len_err: cover property (len_err);
  c_gated_off: cover property (out_ctrl_bit_b && locked ##1 !pump1_en);

endmodule : ssl_ctrl

/* tb/ssl_ser_host.sv */
// partner model: controller driving the three-wire serial bus
`timescale 1ns/100ps
module ssl_ser_host (
  // clock
  input wire logic mclk,
  // serial bus
  output logic ser_data,
  output logic ser_clk,
  output logic ser_en
);
  // ****************************************************************
  // frame driver
  // ****************************************************************
  // bus idles with enable low and clock standing still
  initial
  begin
    ser_data = 1'b0;
    ser_clk = 1'b0;
    ser_en = 1'b0;
  end

  // hold the present levels for h clock cycles
  task automatic wt(input int h);
    repeat (h) @(posedge mclk);
  endtask : wt

  // one framed word, n bits, most significant bit first
  task automatic send(input logic [23:0] w, input int n, input int h);
    ser_en <= 1'b1;
    wt(h);
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_data <= w[i];
      wt(h);
      ser_clk <= 1'b1;
      wt(h);
      ser_clk <= 1'b0;
    end
    wt(h);
    ser_en <= 1'b0;
    ser_data <= ~ser_data; // released line must not look like stale data
    wt(h);
  endtask : send

  // one clock pulse with enable low, which the device must ignore
  task automatic stray(input int h);
    ser_data <= ~ser_data;
    ser_clk <= 1'b1;
    wt(h);
    ser_clk <= 1'b0;
    wt(h);
  endtask : stray
endmodule : ssl_ser_host

/* tb/synth_serial_load_and_pump_ctrl_tb_top.sv */
// testbench: serial loads, pump modes, interrupts and apb access
`timescale 1ns/100ps
module synth_serial_load_and_pump_ctrl_tb_top;
  // ****************************************************************
  // signals and model state
  // ****************************************************************
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic ser_data, ser_clk, ser_en, sel, win, pdn;
  logic [21:0] afw;
  logic [12:0] rdiv;
  logic [3:0] swc;
  logic psc, mref, mloop, p1, p2, lock_n, err;
  logic [21:0] p;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int exp_a, exp_b, exp_ref, exp_sw, exp_st, en;
  int last_n = 0;
  // frequency word bit left unused in the 8/9 prescaler mode
  localparam int SPARE_BIT = 3;

  // device and serial partner
  ssl_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ser_data(ser_data), .ser_clk(ser_clk), .ser_en(ser_en),
    .freq_word_select(sel), .pump2_in_window(win), .power_down(pdn),
    .active_freq_word(afw), .ref_div_ratio(rdiv), .swallow_count(swc),
    .prescale_sel(psc), .ref_divider_monitor(mref),
    .loop_divider_monitor(mloop), .pump1_en(p1), .pump2_en(p2),
    .lock_detect_n(lock_n), .irq(irq));
  ssl_ser_host host (.mclk(mclk), .ser_data(ser_data), .ser_clk(ser_clk),
    .ser_en(ser_en));

  // ****************************************************************
  // clock, timeout and verdict
  // ****************************************************************
  // 4 ns clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // cycle ceiling against a hung run
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // counts and verdict
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // compare and bus tasks
  // ****************************************************************
  // compare a value
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // compare the phase detector enables
  task automatic chk_pump(input ssl_pkg::ssl_pump_s got,
                          input ssl_pkg::ssl_pump_s exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t pumps %b expected %b", $time, got, exp);
    end
  endtask : chk_pump

  // one apb transfer, then one idle edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // ****************************************************************
  // model
  // ****************************************************************
  // send payload and destination, mirror the effect
  task automatic load(input logic [21:0] pl, input logic [1:0] d, input int n);
    if (d != 2'b11 && exp_ref[15])
      pl[SPARE_BIT] = 1'b0;
    last_n = n;
    host.send({pl, d}, n, 4 + $urandom % 3);
    if (d == 2'b11 ? n != 18 : n != 24)
      exp_st |= 32'h10;
    else
    begin
      case (d)
        2'b00: exp_a = pl;
        2'b10: exp_b = pl;
        2'b01: exp_sw = pl[3:0];
        default: exp_ref = pl[15:0];
      endcase
      exp_st |= 1 << (d == 0 ? 0 : d == 2 ? 1 : d == 1 ? 2 : 3);
    end
    repeat (8) @(posedge mclk);
  endtask : load

  // compare every output and the status against the model, then clear
  task automatic check_all();
    logic a, b;
    a = exp_ref[13];
    b = exp_ref[14];
    chk_word(afw, sel ? exp_a : exp_b);
    chk_word({psc, rdiv}, {exp_ref[15], exp_ref[12:0]});
    chk_word(swc, exp_sw[3:0]);
    chk_pump({mref, p1, p2}, {a, b ? !win : !a, 1'b1});
    chk_word({mloop, lock_n}, {a, !win});
    chk_word(irq, (exp_st & en) != 0);
    apb(ssl_pkg::REG_STATUS, 1'b0, 32'h0);
    chk_word(rd, exp_st);
    apb(ssl_pkg::REG_CLEAR, 1'b1, exp_st);
    exp_st = 0;
    chk_word(irq, 1'b0);
    apb(ssl_pkg::REG_FREQ_A, 1'b0, 32'h0);
    chk_word(rd, exp_a);
    apb(ssl_pkg::REG_REF, 1'b0, 32'h0);
    chk_word(rd, exp_ref);
    apb(ssl_pkg::REG_LIVE, 1'b0, 32'h0);
    chk_word(rd, {last_n[4:0], b, a, sel, pdn, win});
  endtask : check_all

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sel, win, pdn, sys_rst} = 4'b1001;
    {exp_a, exp_b, exp_ref, exp_sw, exp_st, en} = '0;
    r = $urandom(48);
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    check_all();
    en = 32'h3f;
    apb(ssl_pkg::REG_IRQ_EN, 1'b1, 32'h3f);
    apb(ssl_pkg::REG_IRQ_EN, 1'b0, 32'h0);
    chk_word(rd, 32'h3f);
    apb(8'h20, 1'b0, 32'h0);
    chk_word(err, 1'b1);
    chk_word(rd, 32'h0);
    // stray clocks, then word a
    host.stray(4);
    host.stray(5);
    load(22'($urandom), 2'b00, 24);
    check_all();
    // word b while powered down, word a kept and read-only
    pdn <= 1'b1;
    load(22'($urandom), 2'b10, 24);
    apb(ssl_pkg::REG_FREQ_A, 1'b1, 32'h0);
    sel <= 1'b0;
    // select passes the synchroniser and the output register
    repeat (6) @(posedge mclk);
    check_all();
    pdn <= 1'b0;
    load(22'($urandom), 2'b01, 24);
    check_all();
    // wrong lengths are dropped, with events masked
    en = 0;
    apb(ssl_pkg::REG_IRQ_EN, 1'b1, 32'h0);
    load(22'($urandom), 2'b00, 23);
    load(22'($urandom), 2'b11, 24);
    check_all();
    en = 32'h3f;
    apb(ssl_pkg::REG_IRQ_EN, 1'b1, 32'h3f);
    // every output-control mode, unlocked and locked
    for (int m = 0; m < 4; m++)
    begin
      for (int wv = 0; wv < 2; wv++)
      begin
        if (wv[0] != win)
          exp_st |= 32'h20;
        win <= wv[0];
        p = 22'($urandom);
        p[14:13] = m[1:0];
        load(p, 2'b11, 18);
        sel <= ~sel;
        repeat (6) @(posedge mclk);
        check_all();
      end
    end
    end_of_test();
  end
endmodule : synth_serial_load_and_pump_ctrl_tb_top
